// ### hdl/eil_pkg.sv
// Package: register map, field positions and reset values of the block
package eil_pkg;
  localparam int unsigned         EIL_ADDR_W          = 4;
  // Register byte offsets
  localparam logic [3:0]          EIL_OFF_STATUS_CTRL = 4'h0;
  localparam logic [3:0]          EIL_OFF_BREAK_CTRL  = 4'h4;
  localparam logic [3:0]          EIL_OFF_VECTOR      = 4'h8;
  // Status/control field positions
  localparam int unsigned         EIL_BIT_MODE        = 0;
  localparam int unsigned         EIL_BIT_MASK        = 1;
  localparam int unsigned         EIL_BIT_ACK         = 2;
  localparam int unsigned         EIL_BIT_PEND        = 3;
  localparam int unsigned         EIL_BIT_PIN         = 4;
  // Break control field position
  localparam int unsigned         EIL_BIT_BCE         = 0;
  // Reset values
  localparam logic                EIL_RST_MODE        = 1'b0;
  localparam logic                EIL_RST_MASK        = 1'b0;
  localparam logic                EIL_RST_BCE         = 1'b0;
  // Fixed vector locations
  localparam logic [15:0]         EIL_VEC_ADDR_HI     = 16'hFFFA;
  localparam logic [15:0]         EIL_VEC_ADDR_LO     = 16'hFFFB;
  // AXI responses
  localparam logic [1:0]          EIL_RESP_OKAY       = 2'h0;
  localparam logic [1:0]          EIL_RESP_SLVERR     = 2'h2;
endpackage

// ### hdl/eil_pin_sync.sv
// Two-stage synchroniser with falling-edge detection for the interrupt pin
`timescale 1ns/1ps
module eil_pin_sync
  import eil_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic pin_n,
  output logic      pin_level,
  output logic      fall_pulse
);
  logic meta_reg;
  logic meta_next;
  logic sync_reg;
  logic sync_next;
  logic prev_reg;
  logic prev_next;
  logic meta_ok_reg;
  logic meta_ok_next;
  logic sync_ok_reg;
  logic sync_ok_next;

  // Level stages reset to the pin's idle high; the previous-sample stage
  // only takes real samples, so a pin held low across reset gives no false
  // falling edge. Limitation: a fall within one edge of release is missed.
  always_comb
  begin
    meta_next    = pin_n;
    sync_next    = meta_reg;
    meta_ok_next = 1'b1;
    sync_ok_next = meta_ok_reg;
    prev_next    = sync_reg & sync_ok_reg;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_reg    <= 1'b1;
      sync_reg    <= 1'b1;
      prev_reg    <= 1'b0;
      meta_ok_reg <= 1'b0;
      sync_ok_reg <= 1'b0;
    end
    else
    begin
      meta_reg    <= meta_next;
      sync_reg    <= sync_next;
      prev_reg    <= prev_next;
      meta_ok_reg <= meta_ok_next;
      sync_ok_reg <= sync_ok_next;
    end
  end

  assign pin_level  = sync_reg;
  assign fall_pulse = prev_reg & ~sync_reg;
endmodule

// ### hdl/eil_axil_slave.sv
// AXI4-Lite slave front end: one write and one read at a time
`timescale 1ns/1ps
module eil_axil_slave
  import eil_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [EIL_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [EIL_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output logic                       wr_en,
  output logic [EIL_ADDR_W-1:0]      wr_addr,
  output logic [31:0]                wr_data,
  output logic [3:0]                 wr_strb,
  input  wire logic                  wr_err,
  output logic                       rd_en,
  output logic [EIL_ADDR_W-1:0]      rd_addr,
  input  wire logic [31:0]           rd_data,
  input  wire logic                  rd_err
);
  logic                  aw_have_reg;
  logic                  aw_have_next;
  logic [EIL_ADDR_W-1:0] aw_addr_reg;
  logic [EIL_ADDR_W-1:0] aw_addr_next;
  logic                  w_have_reg;
  logic                  w_have_next;
  logic [31:0]           w_data_reg;
  logic [31:0]           w_data_next;
  logic [3:0]            w_strb_reg;
  logic [3:0]            w_strb_next;
  logic                  bvalid_reg;
  logic                  bvalid_next;
  logic [1:0]            bresp_reg;
  logic [1:0]            bresp_next;
  logic                  rvalid_reg;
  logic                  rvalid_next;
  logic [31:0]           rdata_reg;
  logic [31:0]           rdata_next;
  logic [1:0]            rresp_reg;
  logic [1:0]            rresp_next;

  // Address and data are taken in either order, each held until both are in
  assign s_axi_awready = ~aw_have_reg & ~bvalid_reg;
  assign s_axi_wready  = ~w_have_reg & ~bvalid_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign wr_en         = aw_have_reg & w_have_reg & ~bvalid_reg;
  assign wr_addr       = aw_addr_reg;
  assign wr_data       = w_data_reg;
  assign wr_strb       = w_strb_reg;
  assign rd_en         = s_axi_arvalid & s_axi_arready;
  assign rd_addr       = s_axi_araddr;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  always_comb
  begin
    aw_have_next = aw_have_reg;
    aw_addr_next = aw_addr_reg;
    w_have_next  = w_have_reg;
    w_data_next  = w_data_reg;
    w_strb_next  = w_strb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_have_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_have_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (wr_en)
    begin
      aw_have_next = 1'b0;
      w_have_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = wr_err ? EIL_RESP_SLVERR : EIL_RESP_OKAY;
    end
    else if (bvalid_reg && s_axi_bready)
    begin
      bvalid_next = 1'b0;
    end
    if (rd_en)
    begin
      rvalid_next = 1'b1;
      rdata_next  = rd_data;
      rresp_next  = rd_err ? EIL_RESP_SLVERR : EIL_RESP_OKAY;
    end
    else if (rvalid_reg && s_axi_rready)
    begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_have_reg  <= 1'b0;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= EIL_RESP_OKAY;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= EIL_RESP_OKAY;
    end
    else
    begin
      aw_have_reg <= aw_have_next;
      aw_addr_reg <= aw_addr_next;
      w_have_reg  <= w_have_next;
      w_data_reg  <= w_data_next;
      w_strb_reg  <= w_strb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
    end
  end
endmodule

// ### hdl/eil_top.sv
// External interrupt latch: trigger, acknowledge, mask and register file
// Notes on behaviour
// - A low on the interrupt pin sets the latch per trigger mode.
// - A CPU vector fetch acknowledge clears the latch.
// - Writing one to the acknowledge bit clears the latch.
// - Reset clears latch and trigger mode, even with pin held low.
// - Edge-only mode: any acknowledge clears the request at once.
// - Edge-and-level mode: clears after acknowledge and pin high, any order.
// - Edge-and-level mode: request stays pending while the pin is low.
// - Mask set withholds the request from priority logic.
// - Pending flag shows the latch regardless of mask.
// - A falling edge after an acknowledge latches a new request.
// - Serviced request takes its vector from the two fixed locations.
// - Break-clear enable one lets break-state acknowledges clear the latch.
// - Break-clear enable zero makes break-state acknowledge-bit writes do nothing.
// - Raw pin level is offered to branch-on-pin instructions.
// - Acknowledge bit is write-only, reads zero, reset clears it.
// - Writing one to the mask bit disables requests; reset clears it.
`timescale 1ns/1ps
module eil_top
  import eil_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  ext_int_pin_n,
  input  wire logic                  vector_fetch_ack,
  input  wire logic                  break_state,
  output logic                       ext_int_request,
  output logic                       ext_int_pin_level,
  output logic [15:0]                vector_addr_hi,
  output logic [15:0]                vector_addr_lo,
  input  wire logic [EIL_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [EIL_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready
);
  logic                  pin_level;
  logic                  fall_pulse;
  logic                  wr_en;
  logic [EIL_ADDR_W-1:0] wr_addr;
  logic [31:0]           wr_data;
  logic [3:0]            wr_strb;
  logic                  wr_err;
  logic                  rd_en;
  logic [EIL_ADDR_W-1:0] rd_addr;
  logic [31:0]           rd_data;
  logic                  rd_err;

  logic                  mode_reg;
  logic                  mode_next;
  logic                  mask_reg;
  logic                  mask_next;
  logic                  bce_reg;
  logic                  bce_next;
  logic                  latch_reg;
  logic                  latch_next;
  logic                  acked_reg;
  logic                  acked_next;

  logic                  sw_ack;
  logic                  any_ack;
  logic                  set_evt;
  logic                  wr_status;
  logic                  wr_break;
  logic                  ack_allowed;

  // Register decode, shared by the write and read paths
  function automatic logic is_mapped(input logic [EIL_ADDR_W-1:0] a);
    is_mapped = (a == EIL_OFF_STATUS_CTRL) || (a == EIL_OFF_BREAK_CTRL) ||
                (a == EIL_OFF_VECTOR);
  endfunction

  // Write of byte lane 0 to one register; only that lane holds defined bits
  function automatic logic lane0_write(input logic                  en,
                                       input logic [3:0]            strb,
                                       input logic [EIL_ADDR_W-1:0] a,
                                       input logic [EIL_ADDR_W-1:0] off);
    lane0_write = en && strb[0] && (a == off);
  endfunction

  eil_pin_sync u_sync (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .pin_n      (ext_int_pin_n),
    .pin_level  (pin_level),
    .fall_pulse (fall_pulse)
  );

  eil_axil_slave u_bus (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_en         (wr_en),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_strb       (wr_strb),
    .wr_err        (wr_err),
    .rd_en         (rd_en),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data),
    .rd_err        (rd_err)
  );

  assign wr_err = ~is_mapped(wr_addr);
  assign rd_err = ~is_mapped(rd_addr);

  assign wr_status = lane0_write(wr_en, wr_strb, wr_addr, EIL_OFF_STATUS_CTRL);
  assign wr_break  = lane0_write(wr_en, wr_strb, wr_addr, EIL_OFF_BREAK_CTRL);

  // Acknowledge bit has no storage: a write of one is a single-cycle strobe.
  // In break state it is dropped unless break-clear is enabled, so a
  // debugger poking the status word cannot lose a pending event.
  assign ack_allowed = !break_state || bce_reg;
  assign sw_ack      = wr_status && wr_data[EIL_BIT_ACK] &&
                       ack_allowed;
  assign any_ack     = sw_ack | vector_fetch_ack;

  // Edge mode sets on falling edge only; level mode also on a held low
  assign set_evt = fall_pulse | (mode_reg & ~pin_level);

  // Control group: trigger mode, mask and break-clear enable
  always_comb
  begin
    mode_next = mode_reg;
    mask_next = mask_reg;
    bce_next  = bce_reg;
    if (wr_status)
    begin
      mode_next = wr_data[EIL_BIT_MODE];
      mask_next = wr_data[EIL_BIT_MASK];
    end
    if (wr_break)
    begin
      bce_next = wr_data[EIL_BIT_BCE];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_reg <= EIL_RST_MODE;
      mask_reg <= EIL_RST_MASK;
      bce_reg  <= EIL_RST_BCE;
    end
    else
    begin
      mode_reg <= mode_next;
      mask_reg <= mask_next;
      bce_reg  <= bce_next;
    end
  end

  // Latch group: the request latch and the level-mode acknowledge memory
  always_comb
  begin
    latch_next = latch_reg;
    acked_next = acked_reg;
    if (latch_reg && any_ack)
    begin
      acked_next = 1'b1;
    end
    if (mode_reg)
    begin
      // Clear once acknowledged and the pin is back high, in either order
      if ((acked_reg || any_ack) && pin_level)
      begin
        latch_next = 1'b0;
        acked_next = 1'b0;
      end
      if (!pin_level)
      begin
        latch_next = 1'b1;
      end
    end
    else
    begin
      acked_next = 1'b0;
      if (any_ack)
      begin
        latch_next = 1'b0;
      end
    end
    // A new edge beats a clear in the same cycle so no event is lost
    if (set_evt && !(mode_reg && acked_reg))
    begin
      latch_next = 1'b1;
    end
    if (fall_pulse)
    begin
      latch_next = 1'b1;
      acked_next = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      latch_reg <= 1'b0;
      acked_reg <= 1'b0;
    end
    else
    begin
      latch_reg <= latch_next;
      acked_reg <= acked_next;
    end
  end

  // CPU global mask is applied downstream in the CPU itself
  assign ext_int_request   = latch_reg & ~mask_reg;
  assign ext_int_pin_level = pin_level;
  assign vector_addr_hi    = EIL_VEC_ADDR_HI;
  assign vector_addr_lo    = EIL_VEC_ADDR_LO;

  always_comb
  begin
    rd_data = 32'h0000_0000;
    case (rd_addr)
      EIL_OFF_STATUS_CTRL:
      begin
        rd_data[EIL_BIT_MODE] = mode_reg;
        rd_data[EIL_BIT_MASK] = mask_reg;
        rd_data[EIL_BIT_ACK]  = 1'b0;
        rd_data[EIL_BIT_PEND] = latch_reg;
        rd_data[EIL_BIT_PIN]  = pin_level;
      end
      EIL_OFF_BREAK_CTRL:
      begin
        rd_data[EIL_BIT_BCE] = bce_reg;
      end
      EIL_OFF_VECTOR:
      begin
        rd_data = {EIL_VEC_ADDR_HI, EIL_VEC_ADDR_LO};
      end
      default:
      begin
        rd_data = 32'h0000_0000;
      end
    endcase
  end
endmodule

// ### dv/eil_cpu_model.sv
// CPU side model: fetches the vector when the request is presented
`timescale 1ns/1ps
module eil_cpu_model #(
  parameter int DLY = 3
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ext_int_request,
  input  wire logic irq_gmask,
  output logic      vector_fetch_ack = 1'h0
);
  int cnt = 0;
  // Global mask holds off the fetch, as the CPU would
  always @(posedge aclk)
  begin
    vector_fetch_ack <= 1'h0;
    if (!aresetn || irq_gmask || !ext_int_request || vector_fetch_ack)
      cnt <= 0;
    else if (cnt == DLY)
      vector_fetch_ack <= 1'h1;
    else
      cnt <= cnt + 1;
  end
endmodule

// ### dv/eil_chk.sv
// Checker: port-level properties of the external interrupt latch
`timescale 1ns/1ps
module eil_chk
  import eil_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        ext_int_pin_n,
  input wire logic        vector_fetch_ack,
  input wire logic        ext_int_request,
  input wire logic        ext_int_pin_level,
  input wire logic [15:0] vector_addr_hi,
  input wire logic [15:0] vector_addr_lo,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid
);
  default clocking dc @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Sync stages hold reset values for two edges after release
  logic [1:0] up_reg;
  logic [1:0] up_next;
  always_comb up_next = !aresetn ? 2'h0 : up_reg + {1'h0, up_reg != 2'h3};
  always_ff @(posedge aclk) up_reg <= up_next;
  rst_idle_a:
    assert property (disable iff (1'h0)
      !aresetn |=> !ext_int_request && ext_int_pin_level)
      else $error("request left up by reset");
  vec_loc_a:
    assert property (vector_addr_hi == 16'hFFFA && vector_addr_lo == 16'hFFFB)
      else $error("vector locations wrong");
  pin_lag_a:
    assert property (up_reg == 2'h3 |->
      ext_int_pin_level == $past(ext_int_pin_n, 2))
      else $error("pin level not two samples behind");
  req_rise_a:
    assert property ($rose(ext_int_request) |-> !ext_int_pin_level ||
      !$past(ext_int_pin_level) || $rose(s_axi_bvalid))
      else $error("request rose without cause");
  req_fall_a:
    assert property ($fell(ext_int_request) |-> $rose(s_axi_bvalid) ||
      $past(vector_fetch_ack) || $past(ext_int_pin_n))
      else $error("request fell without cause");
  ack_zero_a:
    assert property (s_axi_rvalid |-> !s_axi_rdata[EIL_BIT_ACK])
      else $error("ack bit read as one");
  wr_resp_a:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write response late");
  resp_drop_a:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
endmodule
bind eil_top eil_chk chk (.aclk, .aresetn, .ext_int_pin_n,
  .vector_fetch_ack, .ext_int_request, .ext_int_pin_level,
  .vector_addr_hi, .vector_addr_lo, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_rdata, .s_axi_rvalid);

// ### dv/external_interrupt_latch_bench.sv
// Bench: register and pin sequences for the external interrupt latch
`timescale 1ns/1ps
module external_interrupt_latch_bench
  import eil_pkg::*;
;
  logic                  aclk = 1'h0;
  logic                  aresetn = 1'h0;
  logic                  ext_int_pin_n = 1'h1;
  logic                  break_state = 1'h0;
  logic                  irq_gmask = 1'h1;
  logic                  s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic                  s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic                  s_axi_rready = 1'h0;
  logic [EIL_ADDR_W-1:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [3:0]            s_axi_wstrb = 4'hF;
  logic [31:0]           s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [15:0]           vector_addr_hi, vector_addr_lo;
  logic [1:0]            s_axi_bresp, s_axi_rresp, rs;
  logic                  vector_fetch_ack, ext_int_request;
  logic                  ext_int_pin_level, s_axi_awready, s_axi_wready;
  logic                  s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  int                    error_cnt = 0, check_count = 0;
  localparam logic [3:0]  SC = EIL_OFF_STATUS_CTRL, BC = EIL_OFF_BREAK_CTRL;
  localparam logic [31:0] MD = 32'h1 << EIL_BIT_MODE;
  localparam logic [31:0] MK = 32'h1 << EIL_BIT_MASK;
  localparam logic [31:0] AK = 32'h1 << EIL_BIT_ACK;
  always #50 aclk = ~aclk;
  eil_top dut (.aclk, .aresetn, .ext_int_pin_n, .vector_fetch_ack,
    .break_state, .ext_int_request, .ext_int_pin_level, .vector_addr_hi,
    .vector_addr_lo, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  eil_cpu_model cpu (.aclk, .aresetn, .ext_int_request, .irq_gmask,
    .vector_fetch_ack);
  function automatic logic [31:0] st(logic p, logic f, logic m, logic d);
    st = 32'h0;
    st[EIL_BIT_PIN] = p;
    st[EIL_BIT_PEND] = f;
    st[EIL_BIT_MASK] = m;
    st[EIL_BIT_MODE] = d;
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end
    while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'h0;
    @(posedge aclk);
  endtask
  task automatic rc(input logic [3:0] a, input logic [31:0] e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end
    while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'h0;
    @(posedge aclk);
    chk(rd, e);
  endtask
  // Pin changes pass a two-stage synchroniser, so allow six edges
  task automatic pn(input logic v);
    ext_int_pin_n <= v;
    repeat (6) @(posedge aclk);
  endtask
  task automatic tally_and_finish;
    if (error_cnt == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge aclk);
    error_cnt++;
    tally_and_finish;
  end
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    rc(SC, st(1, 0, 0, 0));
    rc(BC, 32'h0);
    rc(EIL_OFF_VECTOR, 32'hFFFAFFFB);
    rc(4'hC, 32'h0);
    chk({30'h0, rs}, {30'h0, EIL_RESP_SLVERR});
    wr(4'hC, 32'h1);
    chk({30'h0, rs}, {30'h0, EIL_RESP_SLVERR});
    pn(1'h0);
    rc(SC, st(0, 1, 0, 0));
    chk({31'h0, ext_int_pin_level}, 32'h0);
    chk(ext_int_request, 32'h1);
    wr(SC, AK);
    rc(SC, st(0, 0, 0, 0));
    pn(1'h1);
    pn(1'h0);
    rc(SC, st(0, 1, 0, 0));
    wr(SC, MK | AK);
    pn(1'h1);
    pn(1'h0);
    rc(SC, st(0, 1, 1, 0));
    chk(ext_int_request, 32'h0);
    wr(SC, 32'h0);
    chk(ext_int_request, 32'h1);
    repeat (10) @(posedge aclk);
    chk(ext_int_request, 32'h1);
    irq_gmask <= 1'h0;
    repeat (8) @(posedge aclk);
    chk(ext_int_request, 32'h0);
    irq_gmask <= 1'h1;
    pn(1'h1);
    wr(SC, MD);
    pn(1'h0);
    wr(SC, MD | AK);
    rc(SC, st(0, 1, 0, 1));
    pn(1'h1);
    rc(SC, st(1, 0, 0, 1));
    pn(1'h0);
    pn(1'h1);
    rc(SC, st(1, 1, 0, 1));
    wr(SC, MD | AK);
    rc(SC, st(1, 0, 0, 1));
    pn(1'h0);
    wr(SC, MD | MK);
    chk(ext_int_request, 32'h0);
    aresetn <= 1'h0;
    repeat (3) @(posedge aclk);
    chk(ext_int_request, 32'h0);
    aresetn <= 1'h1;
    // Let the synchroniser refill from the still-low pin before looking
    repeat (6) @(posedge aclk);
    rc(SC, 32'h0);
    chk(rd & (MD | MK), 32'h0);
    pn(1'h1);
    wr(SC, AK);
    pn(1'h0);
    break_state <= 1'h1;
    wr(SC, AK);
    rc(SC, st(0, 1, 0, 0));
    wr(BC, 32'h1);
    rc(BC, 32'h1);
    wr(SC, AK);
    rc(SC, st(0, 0, 0, 0));
    break_state <= 1'h0;
    rc(SC, st(0, 0, 0, 0));
    tally_and_finish;
  end
endmodule
